// File: src/charger_regs_pkg.sv
// Register map, field layout and carrier types of the charger register bank
// ==========================================================================
// What this block does
// - Mask bit 0 enables its interrupt, 1 masks it, in all three masks.
// - Mask one bits 7..0: input OV, input UV, input valid, adaptive, current, bat OV, therm.
// - Mask one resets to 03h: only thermal shutdown and regulation masked.
// - Mask two 7..0: fast timer, no battery, weak, boost, pre timer, restart, done, top-off.
// - Mask two resets to B8h.
// - Mask three bits 3..0 mask rail good, falling, overload, discharge limit; resets FFh.
// - Mask three bits 7:4 are reserved, reset 1111, written as 1111.
// - Masks, control and flags return to reset while system rail is in undervoltage.
// - Status is read only, no reset value; bits 7:5 read zero.
// - Status bit 4 is rail overload with valid input.
// - Status bit 3 is discharge current limit detected.
// - Status bit 2 is die temperature in shutdown band.
// - Status bit 1 is battery present.
// - Status bit 0 mirrors the suspend enable control bit.
// - Control bit 6 turns comparators on, resets to 1.
// - Control bit 2 enters suspend, input switch high impedance; resets to 0.
// - Control bit 1 enables the charger; control resets to 42h.
// - Control bit 0 enables boost output mode; resets to 0.
// - Flag registers 00h..02h latch events, clear on read, reset to zero.
// - Comparator flags set without valid input only when comparators are enabled.
package charger_regs_pkg;

  // ========================================================================
  // Register offsets
  localparam logic [7:0] OFS_FLAGS_INPUT_THERMAL = 8'h00;
  localparam logic [7:0] OFS_FLAGS_CHARGE_TIMERS = 8'h01;
  localparam logic [7:0] OFS_FLAGS_SYSTEM_RAIL   = 8'h02;
  localparam logic [7:0] OFS_IRQ_MASK_INPUT_THERMAL = 8'h03;
  localparam logic [7:0] OFS_IRQ_MASK_CHARGE_TIMERS = 8'h04;
  localparam logic [7:0] OFS_IRQ_MASK_SYSTEM_RAIL   = 8'h05;
  localparam logic [7:0] OFS_LIVE_STATUS            = 8'h06;
  localparam logic [7:0] OFS_ONOFF_CONTROL          = 8'h07;

  // ========================================================================
  // Reset values
  localparam logic [7:0] RST_IRQ_MASK_INPUT_THERMAL = 8'h03;
  localparam logic [7:0] RST_IRQ_MASK_CHARGE_TIMERS = 8'hB8;
  localparam logic [7:0] RST_IRQ_MASK_SYSTEM_RAIL   = 8'hFF;
  localparam logic [7:0] RST_ONOFF_CONTROL          = 8'h42;
  localparam logic [7:0] RST_FLAGS                  = 8'h00;

  // ========================================================================
  // Field positions
  localparam int RAIL_EVENT_W            = 4;
  localparam int CTRL_COMPARATOR_ENABLE  = 6;
  localparam int CTRL_SOFT_RESET         = 3;
  localparam int CTRL_SUSPEND_ENABLE     = 2;
  localparam int CTRL_CHARGER_ENABLE     = 1;
  localparam int CTRL_BOOST_OUTPUT_ENABLE = 0;

  // Flags whose comparators follow the comparator enable bit
  localparam logic [7:0] CMP_GATED_INPUT_THERMAL = 8'h04;
  localparam logic [7:0] CMP_GATED_CHARGE_TIMERS = 8'h20;
  localparam logic [3:0] CMP_GATED_SYSTEM_RAIL   = 4'hD;

  // ========================================================================
  // Carriers
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic rail_overload_state;
    logic discharge_limit_state;
    logic thermal_shutdown_state;
    logic battery_present;
  } analog_status_t;

endpackage : charger_regs_pkg

// File: src/level_sync.sv
// Two-stage synchroniser for levels arriving from the analog side
`timescale 1ns/10ps
module level_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  generate
    if (W < 1) begin : g_bad_width
      $error("level_sync width must be at least 1");
    end
  endgenerate

  logic [W-1:0] stage1;

  // No reset: analog levels have no meaningful reset value
  always_ff @(posedge i_clk) begin
    stage1 <= i_async;
    o_sync <= stage1;
  end
endmodule : level_sync

// File: src/event_flags.sv
// One clear-on-read interrupt flag register with edge capture and gating
`timescale 1ns/10ps
module event_flags #(
  parameter int W = 8
) (
  input  wire logic         i_clk,
  input  wire logic         i_reset,
  input  wire logic [W-1:0] i_event,
  input  wire logic [W-1:0] i_allow,
  input  wire logic         i_clear,
  output logic      [W-1:0] o_flags
);
  generate
    if (W < 1 || W > 8) begin : g_bad_width
      $error("event_flags width must be 1 to 8");
    end
  endgenerate

  logic [W-1:0] event_prev;
  wire  [W-1:0] rise = i_event & ~event_prev & i_allow;

  // A rising edge in the clearing cycle survives the clear
  wire  [W-1:0] next_flags = (i_clear ? {W{1'b0}} : o_flags) | rise;

  // Edge history keeps tracking through reset, so an event still held when
  // reset ends does not raise its flag a second time
  always_ff @(posedge i_clk) begin
    event_prev <= i_event;
    if (i_reset) begin
      o_flags <= '0;
    end else begin
      o_flags <= next_flags;
    end
  end
endmodule : event_flags

// File: src/charger_irq_mask_status_ctrl.sv
// Charger register bank: flags, masks, live status and on/off control
`timescale 1ns/10ps
module charger_irq_mask_status_ctrl (
  input  wire logic                             i_clk,
  input  wire logic                             i_reset,
  // Byte request from the serial bus engine, same clock
  input  wire charger_regs_pkg::reg_req_t       i_reg_req,
  // Analog side, asynchronous
  input  wire logic                             i_sys_uvlo,
  input  wire logic                             i_input_valid,
  input  wire logic [7:0]                       i_events_input_thermal,
  input  wire logic [7:0]                       i_events_charge_timers,
  input  wire logic [3:0]                       i_events_system_rail,
  input  wire charger_regs_pkg::analog_status_t i_analog_status,
  // Register side outputs
  output logic      [7:0]                       o_reg_rdata,
  output logic                                  o_irq_pending,
  // Control to the power stages
  output logic                                  o_comparator_enable,
  output logic                                  o_suspend_enable,
  output logic                                  o_charger_enable,
  output logic                                  o_boost_output_enable,
  output logic                                  o_soft_reset
);

  // ========================================================================
  // Synchronisers
  localparam int SYNC_W = 2 + 8 + 8 + 4 + 4;

  logic [SYNC_W-1:0] sync_out;

  level_sync #(
    .W (SYNC_W)
  ) u_sync (
    .i_clk   (i_clk),
    .i_async ({i_sys_uvlo,
               i_input_valid,
               i_events_input_thermal,
               i_events_charge_timers,
               i_events_system_rail,
               i_analog_status}),
    .o_sync  (sync_out)
  );

  wire                              uvlo        = sync_out[25];
  wire                              input_valid = sync_out[24];
  wire [7:0]                        ev_input    = sync_out[23:16];
  wire [7:0]                        ev_charge   = sync_out[15:8];
  wire [3:0]                        ev_rail     = sync_out[7:4];
  charger_regs_pkg::analog_status_t status_s;
  assign status_s = sync_out[3:0];

  // Undervoltage on the system rail acts as a register reset
  wire bank_reset = i_reset | uvlo;

  // ========================================================================
  // Register storage
  logic [7:0] irq_mask_input_thermal;
  logic [7:0] irq_mask_charge_timers;
  logic [7:0] irq_mask_system_rail;
  logic [7:0] onoff_control;

  // ========================================================================
  // Address decode
  function automatic logic hit(
    input charger_regs_pkg::reg_req_t req,
    input logic [7:0]                 ofs
  );
    hit = (req.addr == ofs);
  endfunction : hit

  wire wr_mask_input = i_reg_req.wr &
    hit(i_reg_req, charger_regs_pkg::OFS_IRQ_MASK_INPUT_THERMAL);
  wire wr_mask_charge = i_reg_req.wr &
    hit(i_reg_req, charger_regs_pkg::OFS_IRQ_MASK_CHARGE_TIMERS);
  wire wr_mask_rail = i_reg_req.wr &
    hit(i_reg_req, charger_regs_pkg::OFS_IRQ_MASK_SYSTEM_RAIL);
  wire wr_control = i_reg_req.wr &
    hit(i_reg_req, charger_regs_pkg::OFS_ONOFF_CONTROL);

  wire rd_flags_input = i_reg_req.rd &
    hit(i_reg_req, charger_regs_pkg::OFS_FLAGS_INPUT_THERMAL);
  wire rd_flags_charge = i_reg_req.rd &
    hit(i_reg_req, charger_regs_pkg::OFS_FLAGS_CHARGE_TIMERS);
  wire rd_flags_rail = i_reg_req.rd &
    hit(i_reg_req, charger_regs_pkg::OFS_FLAGS_SYSTEM_RAIL);

  // ========================================================================
  // Comparator gating
  // Without valid input the comparator-driven events are dropped unless the
  // comparators are on; with valid input they always reach their flags
  wire comparators_live = input_valid |
    onoff_control[charger_regs_pkg::CTRL_COMPARATOR_ENABLE];

  wire [7:0] allow_input = ~charger_regs_pkg::CMP_GATED_INPUT_THERMAL |
    {8{comparators_live}};
  wire [7:0] allow_charge = ~charger_regs_pkg::CMP_GATED_CHARGE_TIMERS |
    {8{comparators_live}};
  wire [3:0] allow_rail = ~charger_regs_pkg::CMP_GATED_SYSTEM_RAIL |
    {4{comparators_live}};

  // ========================================================================
  // Interrupt flags
  logic [7:0] flags_input;
  logic [7:0] flags_charge;
  logic [3:0] flags_rail;

  event_flags #(
    .W (8)
  ) u_flags_input (
    .i_clk   (i_clk),
    .i_reset (bank_reset),
    .i_event (ev_input),
    .i_allow (allow_input),
    .i_clear (rd_flags_input),
    .o_flags (flags_input)
  );

  event_flags #(
    .W (8)
  ) u_flags_charge (
    .i_clk   (i_clk),
    .i_reset (bank_reset),
    .i_event (ev_charge),
    .i_allow (allow_charge),
    .i_clear (rd_flags_charge),
    .o_flags (flags_charge)
  );

  event_flags #(
    .W (charger_regs_pkg::RAIL_EVENT_W)
  ) u_flags_rail (
    .i_clk   (i_clk),
    .i_reset (bank_reset),
    .i_event (ev_rail),
    .i_allow (allow_rail),
    .i_clear (rd_flags_rail),
    .o_flags (flags_rail)
  );

  // ========================================================================
  // Masks and control
  // Bit order of each mask matches its flag register one to one, so a flag
  // and its mask share a position
  always_ff @(posedge i_clk) begin
    if (bank_reset) begin
      irq_mask_input_thermal <= charger_regs_pkg::RST_IRQ_MASK_INPUT_THERMAL;
      irq_mask_charge_timers <= charger_regs_pkg::RST_IRQ_MASK_CHARGE_TIMERS;
      irq_mask_system_rail   <= charger_regs_pkg::RST_IRQ_MASK_SYSTEM_RAIL;
      onoff_control          <= charger_regs_pkg::RST_ONOFF_CONTROL;
    end else begin
      if (wr_mask_input) begin
        irq_mask_input_thermal <= i_reg_req.wdata;
      end
      if (wr_mask_charge) begin
        irq_mask_charge_timers <= i_reg_req.wdata;
      end
      if (wr_mask_rail) begin
        // Reserved upper bits are stored as written; host keeps them 1111
        irq_mask_system_rail <= i_reg_req.wdata;
      end
      if (wr_control) begin
        // Reserved bits 7, 5, 4 are stored as written; the host keeps them 0
        onoff_control <= i_reg_req.wdata;
      end
    end
  end

  // ========================================================================
  // Live status
  // Bits 7:5 carry no meaning and read as zero
  wire [7:0] live_status = {
    3'h0,
    status_s.rail_overload_state,
    status_s.discharge_limit_state,
    status_s.thermal_shutdown_state,
    status_s.battery_present,
    onoff_control[charger_regs_pkg::CTRL_SUSPEND_ENABLE]
  };

  // ========================================================================
  // Read mux
  logic [7:0] next_rdata;

  always_comb begin
    case (i_reg_req.addr)
      charger_regs_pkg::OFS_FLAGS_INPUT_THERMAL:    next_rdata = flags_input;
      charger_regs_pkg::OFS_FLAGS_CHARGE_TIMERS:    next_rdata = flags_charge;
      charger_regs_pkg::OFS_FLAGS_SYSTEM_RAIL:      next_rdata = {4'h0, flags_rail};
      charger_regs_pkg::OFS_IRQ_MASK_INPUT_THERMAL: next_rdata = irq_mask_input_thermal;
      charger_regs_pkg::OFS_IRQ_MASK_CHARGE_TIMERS: next_rdata = irq_mask_charge_timers;
      charger_regs_pkg::OFS_IRQ_MASK_SYSTEM_RAIL:   next_rdata = irq_mask_system_rail;
      charger_regs_pkg::OFS_LIVE_STATUS:            next_rdata = live_status;
      charger_regs_pkg::OFS_ONOFF_CONTROL:          next_rdata = onoff_control;
      default:                                      next_rdata = 8'h00;
    endcase
  end

  // ========================================================================
  // Pending interrupt
  // A zero mask bit lets its flag through
  wire next_irq = |(flags_input  & ~irq_mask_input_thermal) |
                  |(flags_charge & ~irq_mask_charge_timers) |
                  |(flags_rail   & ~irq_mask_system_rail[3:0]);

  // ========================================================================
  // Output registers
  // Read data holds until the next read so a slow serial engine can shift it
  always_ff @(posedge i_clk) begin
    if (bank_reset) begin
      o_reg_rdata   <= 8'h00;
      o_irq_pending <= 1'b0;
    end else begin
      if (i_reg_req.rd) begin
        o_reg_rdata <= next_rdata;
      end
      o_irq_pending <= next_irq;
    end
  end

  // Control bits leave straight from the control register
  assign o_comparator_enable   =
    onoff_control[charger_regs_pkg::CTRL_COMPARATOR_ENABLE];
  assign o_suspend_enable      =
    onoff_control[charger_regs_pkg::CTRL_SUSPEND_ENABLE];
  assign o_charger_enable      =
    onoff_control[charger_regs_pkg::CTRL_CHARGER_ENABLE];
  assign o_boost_output_enable =
    onoff_control[charger_regs_pkg::CTRL_BOOST_OUTPUT_ENABLE];
  // Function of this bit is left to the power stage; it is only stored here
  assign o_soft_reset          = onoff_control[charger_regs_pkg::CTRL_SOFT_RESET];

endmodule : charger_irq_mask_status_ctrl

// File: dv/charger_regs_checker.sv
// Port-level assertions for the charger register bank
`timescale 1ns/10ps
module charger_regs_checker (
  input wire logic                             i_clk,
  input wire logic                             i_reset,
  input wire charger_regs_pkg::reg_req_t       i_reg_req,
  input wire logic                             i_sys_uvlo,
  input wire logic                             i_input_valid,
  input wire logic [7:0]                       i_events_input_thermal,
  input wire logic [7:0]                       i_events_charge_timers,
  input wire logic [3:0]                       i_events_system_rail,
  input wire charger_regs_pkg::analog_status_t i_analog_status,
  input wire logic [7:0]                       o_reg_rdata,
  input wire logic                             o_irq_pending,
  input wire logic                             o_comparator_enable,
  input wire logic                             o_suspend_enable,
  input wire logic                             o_charger_enable,
  input wire logic                             o_boost_output_enable,
  input wire logic                             o_soft_reset
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);
  // ========================================================
  // Helpers
  // Quiet count on event pins: a clear is only judged when no fresh edge can land
  logic [19:0] ev_q;
  logic [2:0]  quiet;
  wire  [19:0] ev    = {i_events_input_thermal, i_events_charge_timers, i_events_system_rail};
  wire         rd_ok = i_reg_req.rd && !i_reg_req.wr;
  wire         cwr   = i_reg_req.wr && i_reg_req.addr == 8'h07;
  wire         srd   = rd_ok && i_reg_req.addr == 8'h06;
  wire  [4:0]  ctl   = {o_comparator_enable, o_soft_reset, o_suspend_enable, o_charger_enable,
                        o_boost_output_enable};
  always_ff @(posedge i_clk) begin
    ev_q  <= ev;
    quiet <= (ev != ev_q) ? 3'h0 : quiet + {2'h0, quiet != 3'h7};
  end
  sequence s_flag_read;
    rd_ok && i_reg_req.addr == 8'h00;
  endsequence
  // ========================================================
  // Assertions
  a_reset_ctrl_vals: assert property (
    $past(i_reset) |-> ctl == 5'h12 && !o_irq_pending) else $error("ctrl not at reset");
  a_ctrl_write_bits: assert property (
    cwr && !$past(i_sys_uvlo, 2) |=> ctl == {$past(i_reg_req.wdata[6]),
    $past(i_reg_req.wdata[3:0])}) else $error("ctrl differs from write");
  a_ctrl_hold: assert property (
    !cwr && !$past(i_sys_uvlo, 2) |=> $stable(ctl)) else $error("ctrl changed unwritten");
  a_uvlo_reset: assert property (
    i_sys_uvlo [*3] |=> ctl == 5'h12 && !o_irq_pending && o_reg_rdata == 8'h00)
    else $error("undervoltage did not reset");
  a_status_fixed: assert property (
    srd && !$past(i_sys_uvlo, 2) |=> o_reg_rdata[7:5] == 3'h0
    && o_reg_rdata[0] == $past(o_suspend_enable)) else $error("status bits 7:5 or 0 wrong");
  a_status_live: assert property (
    srd && $stable(i_analog_status) && i_analog_status == $past(i_analog_status, 2)
    && i_analog_status == $past(i_analog_status, 3) && !$past(i_sys_uvlo, 2)
    |=> o_reg_rdata[4:1] == $past(i_analog_status)) else $error("status bits 4:1 wrong");
  a_flag_clear: assert property (
    quiet >= 3'h4 ##0 s_flag_read ##1 s_flag_read |=> o_reg_rdata == 8'h00)
    else $error("flag not cleared by read");
  a_rdata_hold: assert property (
    !i_reg_req.rd && !$past(i_sys_uvlo, 2) |=> $stable(o_reg_rdata))
    else $error("read data moved without read");
endmodule : charger_regs_checker
bind charger_irq_mask_status_ctrl charger_regs_checker chk_u (
  .i_clk(i_clk), .i_reset(i_reset), .i_reg_req(i_reg_req), .i_sys_uvlo(i_sys_uvlo),
  .i_input_valid(i_input_valid), .i_events_input_thermal(i_events_input_thermal),
  .i_events_charge_timers(i_events_charge_timers), .i_events_system_rail(i_events_system_rail),
  .i_analog_status(i_analog_status), .o_reg_rdata(o_reg_rdata), .o_irq_pending(o_irq_pending),
  .o_comparator_enable(o_comparator_enable), .o_suspend_enable(o_suspend_enable),
  .o_charger_enable(o_charger_enable), .o_boost_output_enable(o_boost_output_enable),
  .o_soft_reset(o_soft_reset));

// File: dv/charger_host_model.sv
// Host model driving single-byte register requests into the bank
`timescale 1ns/10ps
module charger_host_model (
  input  wire logic                  i_clk,
  output charger_regs_pkg::reg_req_t o_reg_req
);
  initial o_reg_req = '0;
  // ========================================================
  // Transfer
  // One request per call, standing for exactly one sampling edge
  task automatic xfer(input logic [7:0] addr, input logic wr, input logic [7:0] data);
    charger_regs_pkg::reg_req_t r;
    r.addr  = addr;
    r.wr    = wr;
    r.rd    = !wr;
    r.wdata = data;
    if (addr == charger_regs_pkg::OFS_IRQ_MASK_SYSTEM_RAIL) r.wdata[7:4] = 4'hF;
    if (addr == charger_regs_pkg::OFS_ONOFF_CONTROL) r.wdata = data & 8'h4F;
    o_reg_req = r;
    @(posedge i_clk);
    #1;
  endtask : xfer
  // Released lines show the inverse, so a stale value never passes for a live one
  task automatic release_bus();
    charger_regs_pkg::reg_req_t r;
    r         = o_reg_req;
    r.addr    = ~r.addr;
    r.wr      = 1'b0;
    r.rd      = 1'b0;
    r.wdata   = ~r.wdata;
    o_reg_req = r;
  endtask : release_bus
endmodule : charger_host_model

// File: dv/tb_charger_irq_mask_status_ctrl.sv
// Self-checking bench for the charger register bank
`timescale 1ns/10ps
module tb_charger_irq_mask_status_ctrl;
  logic                             clk;
  logic                             rst;
  logic                             uvlo;
  logic                             in_valid;
  logic                             irq;
  logic [19:0]                      ev;
  charger_regs_pkg::analog_status_t ana;
  charger_regs_pkg::reg_req_t       req;
  logic [7:0]                       rdata;
  logic [7:0]                       lfsr;
  logic [7:0]                       a;
  logic [7:0]                       m;
  logic [7:0]                       exp_q[$];
  int                               fails;
  int                               compares;
  wire  [4:0]                       outs;
  wire  [7:0]                       ctl = {1'b0, outs[4], 2'h0, outs[3:0]};
  charger_host_model host_u (
    .i_clk     (clk),
    .o_reg_req (req)
  );
  charger_irq_mask_status_ctrl dut_u (
    .i_clk(clk), .i_reset(rst), .i_reg_req(req), .i_sys_uvlo(uvlo), .i_input_valid(in_valid),
    .i_events_input_thermal(ev[19:12]), .i_events_charge_timers(ev[11:4]),
    .i_events_system_rail(ev[3:0]), .i_analog_status(ana), .o_reg_rdata(rdata),
    .o_irq_pending(irq), .o_comparator_enable(outs[4]), .o_suspend_enable(outs[2]),
    .o_charger_enable(outs[1]), .o_boost_output_enable(outs[0]), .o_soft_reset(outs[3]));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ========================================================
  // Tasks
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr_next
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
    exp_q.push_back(exp);
    host_u.xfer(addr, 1'b0, 8'h00);
    host_u.release_bus();
    cyc(1);
  endtask : rd
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    host_u.xfer(addr, 1'b1, data);
    host_u.release_bus();
    cyc(1);
  endtask : wr
  task automatic end_sim();
    $display("Compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim
  // Read data lands on the same edge that samples the read
  always @(posedge clk) begin
    if (req.rd === 1'b1) begin
      #2;
      chk("rdata", exp_q.pop_front(), rdata);
    end
  end
  initial begin
    #200000;
    fails++;
    $display("Error watchdog expected finish seen timeout");
    end_sim();
  end
  // ========================================================
  // Scenarios
  initial begin
    rst = 1'b1;
    uvlo = 1'b0;
    in_valid = 1'b1;
    ev = '0;
    ana = '0;
    fails = 0;
    compares = 0;
    lfsr = 8'h30;
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    chk("ctrl", 8'h42, ctl);
    chk("irq", 8'h00, {7'h0, irq});
    rd(8'h03, 8'h03);
    rd(8'h04, 8'hB8);
    rd(8'h05, 8'hFF);
    rd(8'h07, 8'h42);
    rd(8'h2A, 8'h00);
    for (int i = 0; i < 8; i++) begin
      lfsr = lfsr_next(lfsr);
      ana = lfsr[7:4];
      wr(8'h07, lfsr);
      chk("ctrl", lfsr & 8'h4F, ctl);
      rd(8'h07, lfsr & 8'h4F);
      rd(8'h06, {3'h0, lfsr[7:4], lfsr[2]});
    end
    wr(8'h07, 8'h42);
    wr(8'h03, 8'hFF);
    wr(8'h04, 8'hFF);
    wr(8'h05, 8'hFF);
    for (int k = 0; k < 20; k++) begin
      a = (k >= 12) ? 8'h03 : (k >= 4) ? 8'h04 : 8'h05;
      m = 8'h01 << ((k >= 12) ? k - 12 : (k >= 4) ? k - 4 : k);
      wr(a, ~m);
      ev[k] = 1'b1;
      cyc(6);
      chk("irq", 8'h01, {7'h0, irq});
      wr(a, 8'hFF);
      chk("irq", 8'h00, {7'h0, irq});
      rd(a - 8'h03, m);
      ev[k] = 1'b0;
    end
    // Comparators off with no valid input: only the ungated flag may set
    in_valid = 1'b0;
    wr(8'h07, 8'h02);
    ev[14:13] = 2'h3;
    cyc(6);
    exp_q.push_back(8'h02);
    exp_q.push_back(8'h00);
    host_u.xfer(8'h00, 1'b0, 8'h00);
    host_u.xfer(8'h00, 1'b0, 8'h00);
    host_u.release_bus();
    ev = '0;
    cyc(1);
    wr(8'h07, 8'h42);
    ev[14] = 1'b1;
    cyc(6);
    rd(8'h00, 8'h04);
    wr(8'h03, 8'h00);
    wr(8'h07, 8'h0D);
    uvlo = 1'b1;
    cyc(5);
    uvlo = 1'b0;
    cyc(4);
    chk("ctrl", 8'h42, ctl);
    rd(8'h03, 8'h03);
    rd(8'h07, 8'h42);
    end_sim();
  end
endmodule : tb_charger_irq_mask_status_ctrl
